// ==== include/dvgsr_pkg.sv ====
// Holds the constants and types shared by the dual-channel gain register bank.
// Assumes nothing of its surroundings; it is compiled before the design.
package dvgsr_pkg;

   // ***************************************************************
   // Serial frame layout
   // ***************************************************************
   localparam int         ADDR_W      = 7;
   localparam int         DATA_W      = 8;
   localparam int         FRAME_W     = 16;
   localparam int         REG_COUNT   = 8;
   localparam logic [4:0] CMD_LAST    = 5'h07;
   localparam logic [4:0] FRAME_LAST  = 5'h0F;
   localparam logic [4:0] FRAME_END   = 5'h10;
   localparam int         RW_POS      = 15;

   // ***************************************************************
   // Register offsets
   // ***************************************************************
   localparam logic [6:0] ADDR_REVISION   = 7'h00;
   localparam logic [6:0] ADDR_PRODUCT    = 7'h01;
   localparam logic [6:0] ADDR_SOFT_RESET = 7'h02;
   localparam logic [6:0] ADDR_POWER_DOWN = 7'h03;
   localparam logic [6:0] ADDR_A_BIAS     = 7'h04;
   localparam logic [6:0] ADDR_A_GAIN     = 7'h05;
   localparam logic [6:0] ADDR_B_BIAS     = 7'h06;
   localparam logic [6:0] ADDR_B_GAIN     = 7'h07;

   // ***************************************************************
   // Reset values and gain decoding
   // ***************************************************************
   localparam logic [7:0] RESET_SOFT_RESET = 8'h00;
   localparam logic [7:0] RESET_POWER_DOWN = 8'h00;
   localparam logic [7:0] RESET_BIAS       = 8'h20;
   localparam logic [7:0] RESET_GAIN       = 8'h14;
   localparam logic [7:0] GAIN_CODE_MAX    = 8'h27;
   localparam logic [6:0] GAIN_DB_TOP      = 7'h1E;
   localparam logic [6:0] GAIN_DB_BOTTOM   = 7'h77;

   // One channel's settings as seen by the analog side.
   typedef struct packed {
      logic [7:0] bias;
      logic [7:0] gainCode;
      logic [6:0] gainDb;
   } dvgsr_channel_t;

   // Frame tracking states.
   typedef enum logic [1:0] {
      DVGSR_IDLE  = 2'h1,
      DVGSR_SHIFT = 2'h2
   } dvgsr_state_t;

endpackage

// ==== hw/dvgsr_register_bank.sv ====
// Serially programmed register bank of a dual-channel variable-gain amplifier.
// Assumes a mode-0 serial host whose clock is much slower than the system clock.
`timescale 1ns/10ps
`default_nettype none

module dvgsr_register_bank
   import dvgsr_pkg::*;
#(
   parameter logic [7:0] REVISION_IDENTIFIER = 8'h5A,  // Arbitrary identification value.
   parameter logic [7:0] PRODUCT_IDENTIFIER  = 8'hA5   // Arbitrary identification value.
)(
   // System clock and reset.
   input  wire logic     clock,
   input  wire logic     reset,
   // Serial bus pins.
   input  wire logic     spiClock,
   input  wire logic     spiSelectN,
   input  wire logic     spiDataIn,
   output logic          spiDataOut,
   output logic          spiDataOutEnable,
   // Settings towards the amplifier.
   output dvgsr_channel_t channelA,
   output dvgsr_channel_t channelB,
   output logic [7:0]    powerDownControl,
   output logic [7:0]    softwareResetControl
);

   // ***************************************************************
   // Helper functions
   // ***************************************************************

   // Decodes a gain code into gain in dB, two's complement.
   // Codes above the bottom end have no defined gain; they are held at the bottom end
   // so that a stray code never asks for more gain than the user meant.
   function automatic logic [6:0] decodeGain(input logic [7:0] code);
      logic [6:0] result;
      result = GAIN_DB_BOTTOM;
      if (code <= GAIN_CODE_MAX) begin
         result = GAIN_DB_TOP - code[6:0];
      end
      return result;
   endfunction

   // True for addresses that software may write.
   // The identification registers are read-only and are left out on purpose.
   function automatic logic isWritable(input logic [6:0] addr);
      return (addr >= ADDR_SOFT_RESET) && (addr <= ADDR_B_GAIN);
   endfunction

   // ***************************************************************
   // Pin synchronisers
   // ***************************************************************
   logic [2:0] syncFirst_reg;
   logic [2:0] syncSecond_reg;
   logic       clockLast_reg;

   // The serial pins are asynchronous to the system clock; a metastable first stage
   // must never reach the edge detector, so only the second stage is read.
   // Two flip-flops per pin; only the second stage feeds logic.
   always_ff @(posedge clock) begin
      syncFirst_reg  <= {spiClock, spiSelectN, spiDataIn};
      syncSecond_reg <= syncFirst_reg;
      clockLast_reg  <= syncSecond_reg[2];
   end

   logic sclkSync;
   logic selectNSync;
   logic dataInSync;
   logic sclkRise;
   logic sclkFall;

   // Edge detection on the synchronised serial clock.
   assign sclkSync    = syncSecond_reg[2];
   assign selectNSync = syncSecond_reg[1];
   assign dataInSync  = syncSecond_reg[0];
   assign sclkRise    = sclkSync & ~clockLast_reg;
   assign sclkFall    = ~sclkSync & clockLast_reg;

   // ***************************************************************
   // Frame engine and register storage
   // ***************************************************************
   dvgsr_state_t   state_reg, state_next;
   logic [4:0]     count_reg, count_next;
   logic [15:0]    shift_reg, shift_next;
   logic [7:0]     out_reg, out_next;
   logic           readMode_reg, readMode_next;
   logic           sdo_reg, sdo_next;
   logic           sdoEnable_reg, sdoEnable_next;
   logic [7:0]     regs_reg [REG_COUNT];
   logic [7:0]     regs_next [REG_COUNT];
   dvgsr_channel_t chanA_reg, chanA_next;
   dvgsr_channel_t chanB_reg, chanB_next;

   // Next-state logic: frame tracking, readback and register writes.
   always_comb begin
      state_next     = state_reg;
      count_next     = count_reg;
      shift_next     = shift_reg;
      out_next       = out_reg;
      readMode_next  = readMode_reg;
      sdo_next       = sdo_reg;
      sdoEnable_next = sdoEnable_reg;
      for (int i = 0; i < REG_COUNT; i++) begin
         regs_next[i] = regs_reg[i];
      end
      case (state_reg)
         DVGSR_IDLE: begin
            sdoEnable_next = 1'b0;
            if (!selectNSync) begin
               state_next    = DVGSR_SHIFT;
               count_next    = 5'h00;
               readMode_next = 1'b0;
            end
         end
         DVGSR_SHIFT: begin
            if (selectNSync) begin
               state_next     = DVGSR_IDLE;
               sdoEnable_next = 1'b0;
            end else if (sclkRise && count_reg != FRAME_END) begin
               // Bits beyond the sixteenth are ignored: the counter stops at the frame end.
               shift_next = {shift_reg[14:0], dataInSync};
               count_next = count_reg + 5'h01;
               // After the eighth bit the command byte is complete; a read loads the answer
               // so that it can be shifted out on the following falling edges.
               if (count_reg == CMD_LAST && shift_next[7]) begin
                  readMode_next = 1'b1;
                  case (shift_next[6:0])
                     ADDR_REVISION: out_next = REVISION_IDENTIFIER;
                     ADDR_PRODUCT:  out_next = PRODUCT_IDENTIFIER;
                     default: begin
                        out_next = isWritable(shift_next[6:0])
                                 ? regs_reg[shift_next[2:0]] : 8'h00;
                     end
                  endcase
               end
               // A write only lands on the sixteenth rising edge; a frame cut short before it
               // leaves every register untouched.
               if (count_reg == FRAME_LAST && !shift_next[RW_POS]
                   && isWritable(shift_next[14:8])) begin
                  regs_next[shift_next[10:8]] = shift_next[7:0];
               end
            end else if (sclkFall && readMode_reg && count_reg > CMD_LAST
                         && count_reg != FRAME_END) begin
               // Read data changes after a falling edge, giving the host half a clock of setup.
               sdo_next       = out_reg[7];
               out_next       = {out_reg[6:0], 1'b0};
               sdoEnable_next = 1'b1;
            end
         end
         default: begin
            state_next = DVGSR_IDLE;
         end
      endcase
      // Synchronous reset has the last word over every path above.
      if (reset) begin
         state_next     = DVGSR_IDLE;
         count_next     = 5'h00;
         shift_next     = 16'h0000;
         out_next       = 8'h00;
         readMode_next  = 1'b0;
         sdo_next       = 1'b0;
         sdoEnable_next = 1'b0;
         regs_next[0]   = 8'h00;
         regs_next[1]   = 8'h00;
         regs_next[ADDR_SOFT_RESET[2:0]] = RESET_SOFT_RESET;
         regs_next[ADDR_POWER_DOWN[2:0]] = RESET_POWER_DOWN;
         regs_next[ADDR_A_BIAS[2:0]]     = RESET_BIAS;
         regs_next[ADDR_B_BIAS[2:0]]     = RESET_BIAS;
         regs_next[ADDR_A_GAIN[2:0]]     = RESET_GAIN;
         regs_next[ADDR_B_GAIN[2:0]]     = RESET_GAIN;
      end
   end

   // Channel settings are taken from the next register values, so they change
   // on the same edge as the stored registers.
   always_comb begin
      chanA_next.bias     = regs_next[ADDR_A_BIAS[2:0]];
      chanA_next.gainCode = regs_next[ADDR_A_GAIN[2:0]];
      chanA_next.gainDb   = decodeGain(regs_next[ADDR_A_GAIN[2:0]]);
      chanB_next.bias     = regs_next[ADDR_B_BIAS[2:0]];
      chanB_next.gainCode = regs_next[ADDR_B_GAIN[2:0]];
      chanB_next.gainDb   = decodeGain(regs_next[ADDR_B_GAIN[2:0]]);
   end

   // Registers only.
   always_ff @(posedge clock) begin
      state_reg     <= state_next;
      count_reg     <= count_next;
      shift_reg     <= shift_next;
      out_reg       <= out_next;
      readMode_reg  <= readMode_next;
      sdo_reg       <= sdo_next;
      sdoEnable_reg <= sdoEnable_next;
      chanA_reg     <= chanA_next;
      chanB_reg     <= chanB_next;
      for (int i = 0; i < REG_COUNT; i++) begin
         regs_reg[i] <= regs_next[i];
      end
   end

   // ***************************************************************
   // Outputs
   // ***************************************************************
   // Every output comes straight from a register, so the analog side never sees a glitch.
   assign spiDataOut           = sdo_reg;
   assign spiDataOutEnable     = sdoEnable_reg;
   assign channelA             = chanA_reg;
   assign channelB             = chanB_reg;
   assign powerDownControl     = regs_reg[ADDR_POWER_DOWN[2:0]];
   assign softwareResetControl = regs_reg[ADDR_SOFT_RESET[2:0]];

endmodule

`default_nettype wire

// ==== testbench/dvgsr_spi_host.sv ====
// Serial host model that sends mode-0 frames to the gain register bank.
// Assumes the bench calls xfer and that clock is the bank's system clock.
`timescale 1ns/10ps
`default_nettype none
module dvgsr_spi_host #(
   parameter int HALF = 10
)(
   // System clock.
   input  wire logic clock,
   // Serial pins.
   output var logic  spiClock,
   output var logic  spiSelectN,
   output var logic  spiDataIn,
   input  wire logic spiDataOut
);
   // Idle bus: the serial clock is parked low and the bank is deselected.
   initial begin
      spiClock = 1'b0;
      spiSelectN = 1'b1;
      spiDataIn = 1'b0;
   end
   // Shifts the first nBits bits of a frame out MSB first and gathers the last eight bits
   // returned; fewer than 16 bits cut the frame short.
   task automatic xfer(input logic [15:0] frame, output logic [7:0] rd, input int nBits);
      int i;
      rd = 8'h00;
      @(posedge clock) spiSelectN <= 1'b0;
      for (i = 15; i > 15 - nBits; i--) begin
         @(posedge clock) spiDataIn <= frame[i];
         repeat (HALF) @(posedge clock);
         if (i < 8) begin
            rd = {rd[6:0], spiDataOut};
         end
         spiClock <= 1'b1;
         repeat (HALF) @(posedge clock);
         spiClock <= 1'b0;
      end
      repeat (HALF) @(posedge clock);
      spiSelectN <= 1'b1;
      spiDataIn <= ~spiDataIn;  // A released line must not keep its last value.
      repeat (8) @(posedge clock);
   endtask
endmodule
`default_nettype wire

// ==== testbench/dvgsr_register_bank_sva.sv ====
// Concurrent checks on the ports of the gain register bank.
// Assumes it is bound to the bank and sees only the bank's ports.
`timescale 1ns/10ps
`default_nettype none
module dvgsr_register_bank_sva
   import dvgsr_pkg::*;
(
   // Clock and reset.
   input wire logic           clock,
   input wire logic           reset,
   // Serial pins.
   input wire logic           spiSelectN,
   input wire logic           spiDataOutEnable,
   // Settings towards the amplifier.
   input wire dvgsr_channel_t channelA,
   input wire dvgsr_channel_t channelB,
   input wire logic [7:0]     powerDownControl,
   input wire logic [7:0]     softwareResetControl
);
   // All checks run on the system clock and rest while reset is held.
   default clocking dc @(posedge clock);
   endclocking
   default disable iff (reset);
   // The gain in dB follows the code on both channels.
   a_gain_a_decode: assert property (channelA.gainCode <= GAIN_CODE_MAX |->
      channelA.gainDb == 7'(8'h1E - channelA.gainCode)) else $error("Gain A decode wrong.");
   a_gain_b_decode: assert property (channelB.gainCode <= GAIN_CODE_MAX |->
      channelB.gainDb == 7'(8'h1E - channelB.gainCode)) else $error("Gain B decode wrong.");
   a_gain_top_end: assert property (channelA.gainCode == 8'h00 |->
      channelA.gainDb == GAIN_DB_TOP) else $error("Code zero not at top gain.");
   a_gain_bottom_end: assert property (channelB.gainCode == GAIN_CODE_MAX |->
      channelB.gainDb == GAIN_DB_BOTTOM) else $error("Code 27h not at bottom gain.");
   // Values seen right after reset is released.
   a_reset_chan_values: assert property ($fell(reset) |-> channelA.bias == RESET_BIAS
      && channelB.bias == RESET_BIAS && channelA.gainCode == RESET_GAIN
      && channelB.gainCode == RESET_GAIN) else $error("Channel reset values wrong.");
   a_reset_ctrl_values: assert property ($fell(reset) |-> powerDownControl == 8'h00
      && softwareResetControl == 8'h00) else $error("Control reset values wrong.");
   // The bank drives its data line and changes its power-down and reset controls only within a frame.
   a_enable_when_idle: assert property (spiSelectN [*6] |-> !spiDataOutEnable)
      else $error("Output enabled outside a frame.");
   a_ctrl_in_frame: assert property ((!$stable(powerDownControl) ||
      !$stable(softwareResetControl)) && !$past(reset) |-> !$past(spiSelectN))
      else $error("Change outside frame.");
   a_enable_in_frame: assert property (spiDataOutEnable |-> !$past(spiSelectN, 3))
      else $error("Output enabled after a frame ended.");
   // Main scenarios.
   c_top_gain: cover property (channelA.gainCode == 8'h00);
   c_bottom_gain: cover property (channelB.gainCode == GAIN_CODE_MAX);
   c_read_phase: cover property ($rose(spiDataOutEnable));
endmodule
bind dvgsr_register_bank dvgsr_register_bank_sva i_dvgsr_register_bank_sva (.clock(clock),
   .reset(reset), .spiSelectN(spiSelectN), .spiDataOutEnable(spiDataOutEnable),
   .channelA(channelA), .channelB(channelB), .powerDownControl(powerDownControl),
   .softwareResetControl(softwareResetControl));
`default_nettype wire

// ==== testbench/dvgsr_register_bank_tb.sv ====
// Self-checking bench for the gain register bank, driven through the serial host model.
// Assumes the package, the bank, the host model and the checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module dvgsr_register_bank_tb;
   import dvgsr_pkg::*;
   localparam logic [7:0] REV_ID  = 8'h3C;  // Arbitrary value.
   localparam logic [7:0] PROD_ID = 8'hC3;  // Arbitrary value.
   logic           clock, reset, spiClock, spiSelectN, spiDataIn, spiDataOut, spiDataOutEnable;
   logic [7:0]     powerDownControl, softwareResetControl, rd;
   dvgsr_channel_t channelA, channelB;
   logic [7:0]     codes [5] = '{8'h00, 8'h01, 8'h14, 8'h26, 8'h27};
   int             nErrors = 0;
   int             compares = 0;
   int             i;
   dvgsr_register_bank #(.REVISION_IDENTIFIER(REV_ID), .PRODUCT_IDENTIFIER(PROD_ID)) i_dvgsr_register_bank (
      .clock(clock), .reset(reset), .spiClock(spiClock), .spiSelectN(spiSelectN),
      .spiDataIn(spiDataIn), .spiDataOut(spiDataOut), .spiDataOutEnable(spiDataOutEnable),
      .channelA(channelA), .channelB(channelB), .powerDownControl(powerDownControl),
      .softwareResetControl(softwareResetControl));
   dvgsr_spi_host i_dvgsr_spi_host (.clock(clock), .spiClock(spiClock), .spiSelectN(spiSelectN),
      .spiDataIn(spiDataIn), .spiDataOut(spiDataOut));
   // Compares one byte and reports a mismatch at once.
   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         nErrors++;
         $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   // Register write and checked read over the serial bus.
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      i_dvgsr_spi_host.xfer({1'b0, a, d}, rd, 16);
   endtask
   task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
      i_dvgsr_spi_host.xfer({1'b1, a, 8'h00}, rd, 16);
      check8(rd, exp);
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic conclude();
      $display("Compares: %0d, errors: %0d", compares, nErrors);
      if (nErrors == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // System clock of 8 ns.
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   // Main sequence: reset values, read and write of every register, gain codes.
   initial begin
      reset = 1'b1;
      repeat (6) @(posedge clock);
      reset <= 1'b0;
      repeat (6) @(posedge clock);
      check8(channelA.bias, RESET_BIAS);
      check8({1'b0, channelB.gainDb}, 8'h0A);
      for (i = 0; i < 8; i++) begin
         rdchk(7'(i), i < 2 ? (i ? PROD_ID : REV_ID) : i < 4 ? 8'h00 : i % 2 ? 8'h14 : 8'h20);
      end
      for (i = 0; i < 8; i++) begin
         wr(7'(i), 8'(8'h11 * i + 1));
      end
      wr(7'h12, 8'hEE);
      for (i = 0; i < 8; i++) begin
         rdchk(7'(i), i < 2 ? (i ? PROD_ID : REV_ID) : 8'(8'h11 * i + 1));
      end
      rdchk(7'h12, 8'h00);
      check8(powerDownControl, 8'h34);
      check8(softwareResetControl, 8'h23);
      check8(channelB.bias, 8'h67);
      // A write frame cut after 15 bits must leave its register untouched.
      i_dvgsr_spi_host.xfer({1'b0, ADDR_A_BIAS, 8'h99}, rd, 15);
      rdchk(ADDR_A_BIAS, 8'h45);
      foreach (codes[k]) begin
         wr(ADDR_A_GAIN, codes[k]);
         wr(ADDR_B_GAIN, 8'h27 - codes[k]);
         check8(channelA.gainCode, codes[k]);
         check8({1'b0, channelA.gainDb}, {1'b0, 7'(8'h1E - codes[k])});
         check8({1'b0, channelB.gainDb}, {1'b0, 7'(codes[k] - 8'h09)});
      end
      // A second reset in mid-run must bring every register back to its start value.
      reset <= 1'b1;
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      repeat (6) @(posedge clock);
      check8(powerDownControl, RESET_POWER_DOWN);
      check8(softwareResetControl, RESET_SOFT_RESET);
      check8(channelA.gainCode, RESET_GAIN);
      check8(channelB.bias, RESET_BIAS);
      rdchk(ADDR_B_GAIN, RESET_GAIN);
      rdchk(ADDR_A_BIAS, RESET_BIAS);
      conclude();
   end
   // Cuts a hang short well after the expected run of about 114 us.
   initial begin
      #300000;
      nErrors++;
      $display("ERROR at %0t: watchdog expired", $time);
      conclude();
   end
endmodule
`default_nettype wire
